// ===== bench/dpc_sensor_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// process sensors and speed reference path seen by the controllers
// ----------------------------------------------------------------
module dpc_sensor_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [15:0] ref1_lvl,
  input wire logic [15:0] ref2_lvl,
  input wire logic [15:0] fb1_lvl,
  input wire logic [15:0] fb2_lvl,
  input wire logic ok_a,
  input wire logic ok_b,
  output logic [15:0] ref_src1,
  output logic [15:0] ref_src2,
  output logic [15:0] fb_src1,
  output logic [15:0] fb_src2,
  output logic ext_en_a,
  output logic ext_en_b
);
  // sensor values reach the drive one cycle late, as a sampled transducer would
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_src1 <= 16'h0000;
      ref_src2 <= 16'h0000;
      fb_src1 <= 16'h0000;
      fb_src2 <= 16'h0000;
      ext_en_a <= 1'b0;
      ext_en_b <= 1'b0;
    end else begin
      ref_src1 <= ref1_lvl;
      ref_src2 <= ref2_lvl;
      fb_src1 <= fb1_lvl;
      fb_src2 <= fb2_lvl;
      ext_en_a <= ok_a;
      ext_en_b <= ok_b;
    end
  end
endmodule : dpc_sensor_model

// ===== bench/dpc_top_tb.sv
`timescale 1ns/10ps
`define DPC_TB_CHK(act, exp) begin compares++; if ((act) !== (exp)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (act), (exp)); end end

module dpc_top_tb;
  localparam int SC = 20;
  logic core_clk, rst_n, ce, wr_en, rd_en, ok_a, ok_b, motor_stop, ext_en_a, ext_en_b;
  logic [5:0] addr;
  logic [15:0] wr_data, r1, r2, f1, f2, rd_data, pid1_out, pid2_out;
  logic [15:0] ref_src1, ref_src2, fb_src1, fb_src2;
  int num_errors = 0;
  int compares = 0;
  int n;
  logic [15:0] mexp [8] = '{16'hFE00, 16'hF400, 16'hF200, 16'hFE00,
                            16'hF400, 16'hF900, 16'hFE00, 16'hFC00};
  logic [15:0] p2c [5] = '{16'h0001, 16'h0005, 16'h0009, 16'h0008, 16'h000C};
  logic [15:0] p2o1 [5] = '{16'hFE00, 16'hFE00, 16'hFE00, 16'h0000, 16'h0000};
  logic [15:0] p2o2 [5] = '{16'h0000, 16'hFC00, 16'hFC00, 16'h0000, 16'h0000};

  dpc_top #(.SAMPLE_CYC(SC)) i_dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .ref_src1(ref_src1), .ref_src2(ref_src2), .fb_src1(fb_src1), .fb_src2(fb_src2),
    .ext_en_a(ext_en_a), .ext_en_b(ext_en_b), .pid1_out(pid1_out),
    .pid2_out(pid2_out), .motor_stop(motor_stop));

  dpc_sensor_model i_sensors (.core_clk(core_clk), .rst_n(rst_n), .ref1_lvl(r1),
    .ref2_lvl(r2), .fb1_lvl(f1), .fb2_lvl(f2), .ok_a(ok_a), .ok_b(ok_b),
    .ref_src1(ref_src1), .ref_src2(ref_src2), .fb_src1(fb_src1), .fb_src2(fb_src2),
    .ext_en_a(ext_en_a), .ext_en_b(ext_en_b));

  // ----------------------------------------------------------------
  // register port and timing helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge core_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    `DPC_TB_CHK(rd_data, e)
  endtask : rd

  task automatic wc(input logic [15:0] v);
    wr(6'h00, v);
  endtask : wc

  task automatic smp(input int k);
    repeat (k * SC) @(posedge core_clk);
    #1;
  endtask : smp

  // three samples: one to pick up settings, one through the reference path, one spare
  task automatic settle(input logic [15:0] e);
    smp(3);
    `DPC_TB_CHK(pid1_out, e)
  endtask : settle

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    repeat (30000) @(posedge core_clk);
    num_errors++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 6'h00;
    wr_data = 16'h0000;
    {r1, r2, f1, f2} = '0;
    ok_a = 1'b1;
    ok_b = 1'b1;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(6'h12, 16'h1000);
    rd(6'h17, 16'h4000);
    rd(6'h18, 16'hC000);
    wr(6'h3F, 16'h1234);
    rd(6'h3F, 16'h0000);
    wr(6'h03, 16'hFFFF);
    rd(6'h03, 16'h09C4);
    wr(6'h19, 16'hFFFF);
    rd(6'h19, 16'h7D00);
    wr(6'h19, 16'h0000);
    wr(6'h03, 16'h0000);
    // proportional only, so outputs are twice the error on the first loop and the error itself on the second
    wr(6'h15, 16'h0000);
    wr(6'h16, 16'h0000);
    wr(6'h25, 16'h0000);
    wr(6'h26, 16'h0000);
    wr(6'h05, 16'h1000);
    wr(6'h10, 16'h1000);
    wr(6'h14, 16'h2000);
    wc(16'h0001);
    settle(16'h2000);
    rd(6'h07, 16'h2000);
    wr(6'h12, 16'h0800);
    r1 <= 16'h0400;
    settle(16'h1400);
    wc(16'h0201);
    settle(16'hEC00);
    wc(16'h0001);
    wr(6'h12, 16'h1000);
    r1 <= 16'h0000;
    wr(6'h17, 16'h0800);
    settle(16'h0800);
    wr(6'h10, 16'h0000);
    f1 <= 16'h1000;
    wr(6'h18, 16'hF000);
    settle(16'hF000);
    wc(16'h0003);
    settle(16'hF800);
    wc(16'h0001);
    wr(6'h17, 16'h4000);
    wr(6'h18, 16'hC000);
    wr(6'h14, 16'h1000);
    wr(6'h11, 16'h0400);
    f1 <= 16'h0400;
    wr(6'h13, 16'h2000);
    settle(16'hF000);
    wc(16'h0801);
    settle(16'h1000);
    wc(16'h0005);
    wr(6'h11, 16'h0000);
    wr(6'h13, 16'h1000);
    wr(6'h20, 16'h0800);
    f1 <= 16'h0200;
    f2 <= 16'h0C00;
    for (int m = 0; m < 8; m++) begin
      wr(6'h01, 16'(m));
      settle(mexp[m]);
      `DPC_TB_CHK(pid2_out, 16'hFC00)
    end
    wr(6'h01, 16'h0002);
    wr(6'h05, 16'h2000);
    settle(16'hE400);
    wr(6'h05, 16'h1000);
    f1 <= 16'h0400;
    wc(16'h0105);
    settle(16'hE000);
    wr(6'h01, 16'h0000);
    wc(16'h0045);
    f1 <= 16'h1000;
    settle(16'hE000);
    f1 <= 16'hF000;
    settle(16'h2000);
    wr(6'h01, 16'h0001);
    wc(16'h0085);
    f2 <= 16'h1000;
    settle(16'hE000);
    `DPC_TB_CHK(pid2_out, 16'hE800)
    wr(6'h01, 16'h0000);
    f1 <= 16'h0200;
    f2 <= 16'h0C00;
    for (int i = 0; i < 5; i++) begin
      wc(p2c[i]);
      settle(p2o1[i]);
      `DPC_TB_CHK(pid2_out, p2o2[i])
    end
    wc(16'h0005);
    smp(3);
    ok_a <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    `DPC_TB_CHK(pid1_out, 16'h0000)
    ok_a <= 1'b1;
    // integral only, held against a low ceiling
    wr(6'h14, 16'h0000);
    wr(6'h15, 16'h1000);
    wr(6'h10, 16'h1000);
    f1 <= 16'h0000;
    wr(6'h17, 16'h0400);
    smp(20);
    `DPC_TB_CHK(pid1_out, 16'h0400)
    wr(6'h17, 16'h4000);
    smp(1);
    `DPC_TB_CHK(pid1_out <= 16'h0800, 1'b1)
    wc(16'h0000);
    wr(6'h15, 16'h0000);
    wc(16'h0001);
    settle(16'h0000);
    // sleep and pre-sleep boost
    wr(6'h14, 16'h1000);
    wr(6'h10, 16'h0000);
    wr(6'h04, 16'h1000);
    wc(16'h0031);
    smp(2);
    `DPC_TB_CHK(motor_stop, 1'b1)
    rd(6'h06, 16'h000C);
    wr(6'h10, 16'h2000);
    smp(3);
    `DPC_TB_CHK(motor_stop, 1'b0)
    wr(6'h02, 16'h0800);
    wr(6'h03, 16'h0001);
    rd(6'h06, 16'h0009);
    wr(6'h10, 16'h0000);
    settle(16'h0800);
    `DPC_TB_CHK(motor_stop, 1'b0)
    n = 0;
    while (motor_stop !== 1'b1 && n < 300 * SC) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    `DPC_TB_CHK((n > 90 * SC) && (n < 110 * SC), 1'b1)
    // reference ramp at 1.0 s per full scale: about 16 lsb per sample
    wc(16'h0001);
    wr(6'h19, 16'h000A);
    wr(6'h10, 16'h0400);
    smp(20);
    `DPC_TB_CHK((pid1_out > 16'h0100) && (pid1_out < 16'h0180), 1'b1)
    // clock enable low must freeze the ramp and the outputs
    @(posedge core_clk);
    ce <= 1'b0;
    #1;
    n = pid1_out;
    smp(5);
    `DPC_TB_CHK(pid1_out, 16'(n))
    @(posedge core_clk);
    ce <= 1'b1;
    smp(50);
    `DPC_TB_CHK(pid1_out, 16'h0400)
    // second loop with source added and both of its inversions set
    r2 <= 16'h0200;
    wc(16'h1405);
    smp(3);
    `DPC_TB_CHK(pid2_out, 16'h0200)
    end_sim();
  end
endmodule : dpc_top_tb

// ===== inc/dpc_map.svh
// Function
// [RL1] asymmetric mode: output held between upper limit and lower limit
// [RL2] symmetric mode: output magnitude held to upper limit, lower limit ignored
// [RL3] integrator frozen while the output is clamped by either limit
// [RL4] on sleep attempt with level and time nonzero, boost added for boost time
// [RL5] read-only status bit shows boost function enabled
// [RL6] sleep armed and motor driven: stop motor when output below wake threshold
// [RL7] second enable: 0 off and zeroed, 1 on, 2 follows first controller
// [RL8] combined feedback scaled by factor zero to four after square root; written factor is not limited, up to 16'hFFFF
// [RL9] modes 0 and 1: independent loops, first uses own or second feedback
// [RL10] modes 2 to 5: first feedback is sum, minimum, maximum or average
// [RL11] modes 6 and 7: first loop takes smaller or larger absolute error
// [RL12] three enable bits for first, second and combined square root stages
// [RL13] square root stage gives sign times full scale times root of fraction
// [RL14] disabled controller: output zero, all internal state held at zero
// [RL15] reference is digital value plus source, scaled and optionally inverted
// [RL16] feedback is digital value plus source, scaled and optionally inverted
// [RL17] reference slew limited: full scale step takes configured time, to 3200 s
// [RL18] per sample output is weighted sum of proportional, integral, derivative
`ifndef DPC_MAP_SVH
`define DPC_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DPC_A_CTRL 6'h00
`define DPC_A_MODE 6'h01
`define DPC_A_BLVL 6'h02
`define DPC_A_BTIME 6'h03
`define DPC_A_WAKE 6'h04
`define DPC_A_FBOS 6'h05
`define DPC_A_STATUS 6'h06
`define DPC_A_OUT1 6'h07
`define DPC_A_OUT2 6'h08
// ----------------------------------------------------------------
// per controller settings: 6'h10 + index, 6'h20 + index
// ----------------------------------------------------------------
`define DPC_C_DREF 0
`define DPC_C_DFB 1
`define DPC_C_RSCL 2
`define DPC_C_FSCL 3
`define DPC_C_KP 4
`define DPC_C_KI 5
`define DPC_C_KD 6
`define DPC_C_UPPER 7
`define DPC_C_LOWER 8
`define DPC_C_SLEW 9
`define DPC_C_CNT 4'hA
// ----------------------------------------------------------------
// control bits
// ----------------------------------------------------------------
`define DPC_B_EN1 0
`define DPC_B_SYM 1
`define DPC_B_P2 2
`define DPC_B_SLEEP 4
`define DPC_B_MOTOR 5
`define DPC_B_SQ 6
`define DPC_B_RINV 9
`define DPC_B_FINV 11
// ----------------------------------------------------------------
// values: full scale 100.00 % is 16'h4000, gain 1.000 is 16'h1000
// ----------------------------------------------------------------
`define DPC_FS 16'h4000
`define DPC_NFS 16'hC000
`define DPC_ONE 16'h1000
`define DPC_GAIN_SH 12
`define DPC_INT_SH 4
`define DPC_SLEW_MAX 16'h7D00
`define DPC_BTIME_MAX 16'h09C4
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DPC_CLK_NS 10
`define DPC_SAMPLE_NS 1000000
`define DPC_DECI_NS 100000000
`define DPC_DECI_SMP (`DPC_DECI_NS / `DPC_SAMPLE_NS)

`endif

// ===== inc/dpc_pkg.sv
package dpc_pkg;

  typedef enum logic [2:0] {
    DPC_FB_OWN, DPC_FB_OTHER, DPC_FB_SUM, DPC_FB_MIN,
    DPC_FB_MAX, DPC_FB_AVG, DPC_ERR_MIN, DPC_ERR_MAX
  } dpc_mode_t;

  typedef enum logic [1:0] {DPC_P2_OFF, DPC_P2_ON, DPC_P2_FOLLOW} dpc_p2en_t;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [2:0] mode;
    logic [15:0] boost_lvl;
    logic [15:0] boost_time;
    logic [15:0] wake;
    logic [15:0] fbo_scale;
    logic [1:0][9:0][15:0] cfg;
    logic [1:0][23:0] integ;
    logic [1:0][16:0] eprev;
    logic [1:0][15:0] out;
    logic [16:0] smp_cnt;
    logic [17:0] boost_cnt;
    logic boosting;
    logic stop;
    logic [15:0] rdata;
  } dpc_top_state_t;

  typedef struct packed {
    logic [15:0] value;
    logic [23:0] credit;
  } dpc_slew_state_t;

endpackage : dpc_pkg

// ===== rtl/dpc_slew.sv
`timescale 1ns/10ps
`include "dpc_map.svh"
module dpc_slew (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tick,
  input wire logic clear,
  input wire logic [15:0] target,
  input wire logic [15:0] slew_ds,
  output logic [15:0] value
);
  dpc_pkg::dpc_slew_state_t s;
  dpc_pkg::dpc_slew_state_t n;
  logic [23:0] step;

  // credit grows by full scale per sample and pays the slew time per lsb,
  // so a full scale step spans exactly the programmed time
  always_comb begin
    n = s;
    step = 24'(slew_ds * `DPC_DECI_SMP);
    if (clear) begin
      n = '0;
    end else if (slew_ds == 16'h0000) begin
      n.value = target;
      n.credit = '0;
    end else if (s.value == target) begin
      n.credit = '0;
    end else if (tick) begin
      n.credit = s.credit + {8'h00, `DPC_FS}; // RL17
    end else if (s.credit >= step) begin
      n.credit = s.credit - step; // RL17
      if ($signed(target) > $signed(s.value)) begin
        n.value = s.value + 16'h0001;
      end else begin
        n.value = s.value - 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  assign value = s.value;

  slew_step_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RL17
    ($past(slew_ds) != 16'h0000 && !$past(clear))
    |-> (16'(s.value - $past(s.value)) inside {16'h0000, 16'h0001, 16'hFFFF}))
    else $error("slew moved more than one lsb");

endmodule : dpc_slew

// ===== rtl/dpc_sqrt.sv
`timescale 1ns/10ps
module dpc_sqrt (
  input wire logic [15:0] din,
  output logic [15:0] dout
);
  logic [15:0] mag;
  logic [29:0] rad;
  logic [14:0] root;
  logic [14:0] trial;

  // bitwise root of |din| * full scale keeps the result in percent units
  always_comb begin
    mag = din[15] ? 16'(-$signed(din)) : din;
    rad = {mag[15:0], 14'h0000};
    root = '0;
    trial = '0;
    for (int b = 14; b >= 0; b--) begin
      trial = root | (15'h0001 << b);
      if (trial * trial <= rad) begin
        root = trial;
      end
    end
    dout = din[15] ? 16'(-$signed({1'b0, root})) : {1'b0, root}; // RL13
  end

endmodule : dpc_sqrt

// ===== rtl/dpc_top.sv
`timescale 1ns/10ps
`include "dpc_map.svh"
module dpc_top #(
  parameter int SAMPLE_CYC = `DPC_SAMPLE_NS / `DPC_CLK_NS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [5:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  input wire logic [15:0] ref_src1,
  input wire logic [15:0] ref_src2,
  input wire logic [15:0] fb_src1,
  input wire logic [15:0] fb_src2,
  input wire logic ext_en_a,
  input wire logic ext_en_b,
  output logic [15:0] pid1_out,
  output logic [15:0] pid2_out,
  output logic motor_stop
);
  localparam logic [16:0] SMP_LAST = 17'(SAMPLE_CYC - 1);
  localparam logic signed [33:0] FS_W = 34'sh000004000;
  localparam logic [9:0][15:0] CFG_RST = {16'h0000, `DPC_NFS, `DPC_FS,
    `DPC_ONE, `DPC_ONE, `DPC_ONE, `DPC_ONE, `DPC_ONE, 16'h0000, 16'h0000};

  dpc_pkg::dpc_top_state_t s;
  dpc_pkg::dpc_top_state_t n;
  logic tick;
  logic boost_en;
  logic below;
  logic pick;
  logic [1:0] en;
  logic [1:0] clamped;
  logic [1:0][15:0] rsrc;
  logic [1:0][15:0] fsrc;
  logic [1:0][15:0] ref_tgt;
  logic [1:0][15:0] ref_ramp;
  logic [1:0][15:0] fbv;
  logic [1:0][15:0] hi;
  logic [1:0][15:0] lwr;
  logic [2:0][15:0] sq_in;
  logic [2:0][15:0] sq_out;
  logic [15:0] rv;
  logic [15:0] cf;
  logic [15:0] fbc;
  logic [15:0] r1;
  logic [15:0] wv;
  logic signed [33:0] f1;
  logic signed [33:0] f2;
  logic signed [33:0] a0;
  logic signed [33:0] a1;
  logic signed [33:0] e;
  logic signed [33:0] ii;
  logic signed [33:0] u;
  logic signed [33:0] lo;
  logic [1:0][33:0] err;

  assign rsrc = {ref_src2, ref_src1};
  assign fsrc = {fb_src2, fb_src1};

  function automatic logic signed [33:0] ext(input logic [15:0] v);
    return {{18{v[15]}}, v};
  endfunction : ext

  // saturate to +/- full scale so sums of two sources cannot wrap
  function automatic logic [15:0] sat(input logic signed [33:0] v);
    if (v > FS_W) begin
      return `DPC_FS;
    end
    if (v < -FS_W) begin
      return `DPC_NFS;
    end
    return v[15:0];
  endfunction : sat

  function automatic logic signed [33:0] mulq(input logic signed [33:0] v,
                                              input logic [15:0] g);
    logic signed [33:0] p;
    p = v * $signed({1'b0, g});
    return p >>> `DPC_GAIN_SH;
  endfunction : mulq

  // ----------------------------------------------------------------
  // square root stages and reference ramps
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 3; g++) begin : g_sqrt
    dpc_sqrt u_sqrt (
      .din(sq_in[g]),
      .dout(sq_out[g])
    );
  end

  for (genvar g = 0; g < 2; g++) begin : g_slew
    dpc_slew u_slew (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .ce(ce),
      .tick(tick),
      .clear(!en[g]),
      .target(ref_tgt[g]),
      .slew_ds(s.cfg[g][`DPC_C_SLEW]),
      .value(ref_ramp[g])
    );
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    tick = ce && (s.smp_cnt == SMP_LAST);
    n.smp_cnt = tick ? 17'h00000 : s.smp_cnt + 17'h00001;
    en[0] = s.ctrl[`DPC_B_EN1] & ext_en_a & ext_en_b;
    unique case (dpc_pkg::dpc_p2en_t'(s.ctrl[`DPC_B_P2 +: 2]))
      dpc_pkg::DPC_P2_OFF: en[1] = 1'b0; // RL7
      dpc_pkg::DPC_P2_ON: en[1] = 1'b1; // RL7
      dpc_pkg::DPC_P2_FOLLOW: en[1] = en[0]; // RL7
      default: en[1] = 1'b0;
    endcase
    boost_en = (|s.boost_lvl) && (|s.boost_time); // RL5
    below = en[0] && ($signed(s.out[0]) < $signed(s.wake));

    for (int i = 0; i < 2; i++) begin
      rv = sat(mulq(ext(sat(ext(s.cfg[i][`DPC_C_DREF]) + ext(rsrc[i]))),
                    s.cfg[i][`DPC_C_RSCL])); // RL15
      ref_tgt[i] = s.ctrl[`DPC_B_RINV + i] ? 16'(-$signed(rv)) : rv; // RL15
      rv = sat(mulq(ext(sat(ext(s.cfg[i][`DPC_C_DFB]) + ext(fsrc[i]))),
                    s.cfg[i][`DPC_C_FSCL])); // RL16
      sq_in[i] = s.ctrl[`DPC_B_FINV + i] ? 16'(-$signed(rv)) : rv; // RL16
      fbv[i] = s.ctrl[`DPC_B_SQ + i] ? sq_out[i] : sq_in[i]; // RL12
      hi[i] = s.cfg[i][`DPC_C_UPPER];
      lwr[i] = s.cfg[i][`DPC_C_LOWER];
    end

    // ----------------------------------------------------------------
    // feedback combination
    // ----------------------------------------------------------------
    f1 = ext(fbv[0]);
    f2 = ext(fbv[1]);
    unique case (dpc_pkg::dpc_mode_t'(s.mode))
      dpc_pkg::DPC_FB_OTHER: cf = fbv[1]; // RL9
      dpc_pkg::DPC_FB_SUM: cf = sat(f1 + f2); // RL10
      dpc_pkg::DPC_FB_MIN: cf = (f1 < f2) ? fbv[0] : fbv[1]; // RL10
      dpc_pkg::DPC_FB_MAX: cf = (f1 > f2) ? fbv[0] : fbv[1]; // RL10
      dpc_pkg::DPC_FB_AVG: cf = sat((f1 + f2) >>> 1); // RL10
      dpc_pkg::DPC_FB_OWN, dpc_pkg::DPC_ERR_MIN, dpc_pkg::DPC_ERR_MAX: cf = fbv[0]; // RL9
    endcase
    sq_in[2] = cf;
    fbc = s.ctrl[`DPC_B_SQ + 2] ? sq_out[2] : sq_in[2]; // RL12
    fbc = sat(mulq(ext(fbc), s.fbo_scale)); // RL8
    r1 = sat(ext(ref_ramp[0]) + (s.boosting ? ext(s.boost_lvl) : 34'sh000000000)); // RL4
    err[0] = ext(r1) - ext(fbc);
    err[1] = ext(ref_ramp[1]) - ext(fbv[1]); // RL9
    a0 = $signed(err[0]) < 0 ? -$signed(err[0]) : $signed(err[0]);
    a1 = $signed(err[1]) < 0 ? -$signed(err[1]) : $signed(err[1]);
    pick = (s.mode == 3'(dpc_pkg::DPC_ERR_MAX)) ? (a1 > a0) : (a1 < a0);
    if (s.mode[2:1] == 2'h3 && pick) begin
      err[0] = err[1]; // RL11
    end

    // ----------------------------------------------------------------
    // controllers
    // ----------------------------------------------------------------
    e = '0;
    ii = '0;
    u = '0;
    lo = '0;
    for (int i = 0; i < 2; i++) begin
      e = $signed(err[i]);
      ii = {{10{s.integ[i][23]}}, s.integ[i]}
           + (mulq(e, s.cfg[i][`DPC_C_KI]) >>> `DPC_INT_SH); // RL18
      u = mulq(e, s.cfg[i][`DPC_C_KP]) + ii
          + mulq(e - {{17{s.eprev[i][16]}}, s.eprev[i]}, s.cfg[i][`DPC_C_KD]); // RL18
      lo = s.ctrl[`DPC_B_SYM] ? -ext(hi[i]) : ext(lwr[i]); // RL2
      clamped[i] = (u > ext(hi[i])) || (u < lo);
      if (u > ext(hi[i])) begin
        u = ext(hi[i]); // RL1
      end else if (u < lo) begin
        u = lo; // RL1
      end
      if (!en[i]) begin
        n.out[i] = '0; // RL14
        n.integ[i] = '0; // RL14
        n.eprev[i] = '0; // RL14
      end else if (tick) begin
        n.out[i] = u[15:0];
        n.eprev[i] = e[16:0];
        n.integ[i] = clamped[i] ? s.integ[i] : ii[23:0]; // RL3
      end
    end

    // ----------------------------------------------------------------
    // sleep and pre-sleep boost, stepped once per sample
    // ----------------------------------------------------------------
    if (tick) begin
      if (!(s.ctrl[`DPC_B_SLEEP] && s.ctrl[`DPC_B_MOTOR])) begin
        n.stop = 1'b0;
        n.boosting = 1'b0;
      end else if (s.stop) begin
        n.stop = below;
      end else if (s.boosting) begin
        if (s.boost_cnt == 18'h00000) begin
          n.boosting = 1'b0;
          n.stop = below; // RL6
        end else begin
          n.boost_cnt = s.boost_cnt - 18'h00001;
        end
      end else if (below) begin
        if (boost_en) begin
          n.boosting = 1'b1; // RL4
          n.boost_cnt = 18'(s.boost_time * `DPC_DECI_SMP - 1); // RL4
        end else begin
          n.stop = 1'b1; // RL6
        end
      end
    end

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    wv = wr_data;
    if (addr[3:0] == 4'(`DPC_C_SLEW) && wr_data > `DPC_SLEW_MAX) begin
      wv = `DPC_SLEW_MAX; // RL17
    end
    if (wr_en) begin
      unique case (addr)
        `DPC_A_CTRL: n.ctrl = wr_data;
        `DPC_A_MODE: n.mode = wr_data[2:0];
        `DPC_A_BLVL: n.boost_lvl = wr_data;
        `DPC_A_BTIME: n.boost_time = (wr_data > `DPC_BTIME_MAX) ? `DPC_BTIME_MAX : wr_data;
        `DPC_A_WAKE: n.wake = wr_data;
        `DPC_A_FBOS: n.fbo_scale = wr_data;
        default: begin
          if ((addr[5] ^ addr[4]) && addr[3:0] < `DPC_C_CNT) begin
            n.cfg[addr[5]][addr[3:0]] = wv;
          end
        end
      endcase
    end
    n.rdata = '0;
    if (rd_en) begin
      unique case (addr)
        `DPC_A_CTRL: n.rdata = s.ctrl;
        `DPC_A_MODE: n.rdata = {13'h0000, s.mode};
        `DPC_A_BLVL: n.rdata = s.boost_lvl;
        `DPC_A_BTIME: n.rdata = s.boost_time;
        `DPC_A_WAKE: n.rdata = s.wake;
        `DPC_A_FBOS: n.rdata = s.fbo_scale;
        `DPC_A_STATUS: n.rdata = {11'h000, en, s.stop, s.boosting, boost_en}; // RL5
        `DPC_A_OUT1: n.rdata = s.out[0];
        `DPC_A_OUT2: n.rdata = s.out[1];
        default: begin
          if ((addr[5] ^ addr[4]) && addr[3:0] < `DPC_C_CNT) begin
            n.rdata = s.cfg[addr[5]][addr[3:0]];
          end
        end
      endcase
    end
  end

  // writes and reads while ce is low are lost: the port is frozen too
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.cfg <= {CFG_RST, CFG_RST};
    end else if (ce) begin
      s <= n;
    end
  end

  assign rd_data = s.rdata;
  assign pid1_out = s.out[0];
  assign pid2_out = s.out[1];
  assign motor_stop = s.stop;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  asym_clamp_a: assert property ( // RL1
    $past(tick && en[0] && !s.ctrl[`DPC_B_SYM] && ($signed(lwr[0]) <= $signed(hi[0])))
    |-> ($signed(s.out[0]) <= $signed($past(hi[0])))
     && ($signed(s.out[0]) >= $signed($past(lwr[0]))))
    else $error("output outside upper or lower limit");

  sym_clamp_a: assert property ( // RL2
    $past(tick && en[0] && s.ctrl[`DPC_B_SYM] && !hi[0][15])
    |-> ($signed(s.out[0]) <= $signed($past(hi[0])))
     && ($signed(s.out[0]) >= -$signed($past(hi[0]))))
    else $error("output magnitude above upper limit");

  int_hold_a: assert property ( // RL3
    $past(tick && en[0] && clamped[0]) |-> s.integ[0] == $past(s.integ[0]))
    else $error("integrator moved while clamped");

  off_zero_a: assert property ( // RL14
    !en[0] |=> (s.out[0] == 16'h0000) && (s.integ[0] == 24'h000000)
            && (s.eprev[0] == 17'h00000))
    else $error("disabled controller state not zero");

  p2_off_a: assert property ( // RL7
    (s.ctrl[`DPC_B_P2 +: 2] == 2'h0) |=> s.out[1] == 16'h0000 && s.integ[1] == 24'h000000)
    else $error("second controller active while off");

  boost_stat_a: assert property ( // RL5
    rd_en && addr == `DPC_A_STATUS |=> rd_data[0] == $past(boost_en))
    else $error("boost status bit wrong");

  stop_cause_a: assert property ( // RL6
    $rose(s.stop) |-> $past(tick) && $past(below))
    else $error("motor stopped without low output");

  sqrt_bound_a: assert property ( // RL13
    !sq_in[2][15]
    |-> (int'(sq_out[2]) * int'(sq_out[2]) <= int'(sq_in[2]) * 16384)
     && ((int'(sq_out[2]) + 1) * (int'(sq_out[2]) + 1) > int'(sq_in[2]) * 16384))
    else $error("square root result out of bounds");

endmodule : dpc_top
